// *** core/port_error_capture_regs.svh ***
// Purpose: Register offsets, field values and reset values of the
//          per-port error capture bank.
// Assumes: Byte addresses on an 8-bit AXI4-Lite address, 32-bit words.
// Notes:   Types live in port_error_capture_pkg.
`ifndef PORT_ERROR_CAPTURE_REGS_SVH
`define PORT_ERROR_CAPTURE_REGS_SVH
`define NUM_PORTS 4
`define BANK_BIT 7
`define PORT_IDX_HI 6
`define PORT_IDX_LO 5
`define SEL_HI 4
`define SEL_LO 2
`define ATTR_SEL 3'h0
`define LAST_SEL 3'h4
`define NO_SEL 3'h7
`define IRQ_STATUS_ADDR 8'h80
`define IRQ_CLEAR_ADDR 8'h84
`define IRQ_ENABLE_ADDR 8'h88
`define KIND_PACKET 2'h0
`define KIND_CTRL_SYM 2'h1
`define KIND_VENDOR 2'h2
`define KIND_SBIT 2'h3
`define CAPTURE_RESET 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** core/port_error_capture_pkg.sv ***
// Purpose: Types shared by the error capture bank.
// Assumes: Nothing beyond the register header.
// Notes:   Attribute layout follows the register bit order.
package port_error_capture_pkg;
  typedef logic [7:0] reg_addr_t;
  typedef logic [3:0][31:0] hdr_words_t;

  typedef struct packed {
    logic [1:0] kind;
    logic rsvd_hi;
    logic [4:0] err_code;
    logic [19:0] extra;
    logic [2:0] rsvd_lo;
    logic valid;
  } attr_t;

  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [4:0] err_code;
    logic [19:0] extra;
    hdr_words_t words;
  } capture_req_t;

  typedef struct packed {
    logic valid;
    reg_addr_t addr;
    logic [31:0] data;
    logic [3:0] strb;
  } reg_wr_t;
endpackage : port_error_capture_pkg

// *** core/capture_port.sv ***
// Purpose: One port's capture set: attribute word and four header words.
// Assumes: Error requests are synchronous one-cycle strobes.
// Notes:   The contents stay readable after unlock until the next capture.
`timescale 1ns/1ps
`include "port_error_capture_regs.svh"
module capture_port (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input port_error_capture_pkg::capture_req_t req_in,
  input wire logic clear_in,
  output port_error_capture_pkg::attr_t attr_out,
  output port_error_capture_pkg::hdr_words_t words_out,
  output logic event_out
);
  logic take;

  // A request is taken only while the set is unlocked.
  assign take = req_in.valid && !attr_out.valid;
  assign event_out = take;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      attr_out <= '0;
    end else if (take) begin
      attr_out.kind <= req_in.kind;
      attr_out.rsvd_hi <= 1'b0;
      attr_out.err_code <= req_in.err_code;
      attr_out.extra <= req_in.extra;
      attr_out.rsvd_lo <= 3'h0;
      attr_out.valid <= 1'b1;
    end else if (clear_in) begin
      attr_out.valid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      words_out <= {4{`CAPTURE_RESET}};
    end else if (take) begin
      words_out[0] <= req_in.words[0];
      if (req_in.kind == `KIND_CTRL_SYM) begin
        words_out[3:1] <= {3{`CAPTURE_RESET}};
      end else begin
        words_out[1] <= req_in.words[1];
        words_out[2] <= req_in.words[2];
        words_out[3] <= req_in.words[3];
      end
    end
  end
endmodule : capture_port

// *** core/axil_reg_slave.sv ***
// Purpose: AXI4-Lite slave front end turning bus transfers into strobes.
// Assumes: One write and one read outstanding at most.
// Notes:   Address and data of a write may arrive in either order.
`timescale 1ns/1ps
`include "port_error_capture_regs.svh"
module axil_reg_slave (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input port_error_capture_pkg::reg_addr_t awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input port_error_capture_pkg::reg_addr_t araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  output port_error_capture_pkg::reg_wr_t wr_out,
  input wire logic wr_err_in,
  output logic rd_fire_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_err_in
);
  logic aw_held_r;
  logic w_held_r;
  port_error_capture_pkg::reg_addr_t addr_r;
  logic [31:0] data_r;
  logic [3:0] strb_r;
  logic fire;

  assign awready_out = !aw_held_r;
  assign wready_out = !w_held_r;
  assign fire = aw_held_r && w_held_r && !bvalid_out;
  assign wr_out = '{valid: fire, addr: addr_r, data: data_r, strb: strb_r};
  assign arready_out = !rvalid_out;
  assign rd_fire_out = arvalid_in && arready_out;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      addr_r <= '0;
      data_r <= '0;
      strb_r <= '0;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_held_r <= 1'b1;
        addr_r <= awaddr_in;
      end else if (fire) begin
        aw_held_r <= 1'b0;
      end
      if (wvalid_in && wready_out) begin
        w_held_r <= 1'b1;
        data_r <= wdata_in;
        strb_r <= wstrb_in;
      end else if (fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bvalid_out <= 1'b0;
      bresp_out <= `RESP_OKAY;
    end else if (fire) begin
      bvalid_out <= 1'b1;
      bresp_out <= wr_err_in ? `RESP_SLVERR : `RESP_OKAY;
    end else if (bready_in) begin
      bvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rvalid_out <= 1'b0;
      rdata_out <= '0;
      rresp_out <= `RESP_OKAY;
    end else if (rd_fire_out) begin
      rvalid_out <= 1'b1;
      rdata_out <= rd_data_in;
      rresp_out <= rd_err_in ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rready_in) begin
      rvalid_out <= 1'b0;
    end
  end
endmodule : axil_reg_slave

// *** core/port_error_capture.sv ***
// Purpose: Four-port error capture bank with AXI4-Lite access and an
//          interrupt raised on each new capture.
// Assumes: Error requests come from the link logic on sys_clk_in.
// Notes:   Port n occupies byte addresses 0x20*n to 0x20*n+0x10.
`timescale 1ns/1ps
`include "port_error_capture_regs.svh"
module port_error_capture (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input port_error_capture_pkg::capture_req_t capture_req_in [`NUM_PORTS],
  input port_error_capture_pkg::reg_addr_t awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input port_error_capture_pkg::reg_addr_t araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic irq_out
);
  // ******************************************************************
  // Declarations
  // ******************************************************************
  port_error_capture_pkg::reg_wr_t wr;
  port_error_capture_pkg::attr_t attr [`NUM_PORTS];
  port_error_capture_pkg::hdr_words_t words [`NUM_PORTS];
  logic [`NUM_PORTS-1:0] capture_event;
  logic [`NUM_PORTS-1:0] clear_valid;
  logic [`NUM_PORTS-1:0] irq_status_r;
  logic [`NUM_PORTS-1:0] irq_status_nxt;
  logic [`NUM_PORTS-1:0] irq_enable_r;
  logic [`NUM_PORTS-1:0] irq_clear;
  logic rd_fire;
  logic [31:0] rd_data;
  logic rd_err;
  logic wr_err;
  logic [2:0] wr_sel;
  logic [1:0] wr_port;
  logic enable_wr;

  // ******************************************************************
  // Address decode helpers
  // ******************************************************************
  // Returns the register slot within a port window, or NO_SEL.
  function automatic logic [2:0] port_sel(
    input port_error_capture_pkg::reg_addr_t a);
    logic [2:0] s;
    s = a[`SEL_HI:`SEL_LO];
    if (a[`BANK_BIT] || a[1:0] != 2'h0 || s > `LAST_SEL) begin
      port_sel = `NO_SEL;
    end else begin
      port_sel = s;
    end
  endfunction : port_sel

  function automatic logic [1:0] port_idx(
    input port_error_capture_pkg::reg_addr_t a);
    port_idx = a[`PORT_IDX_HI:`PORT_IDX_LO];
  endfunction : port_idx

  function automatic logic is_irq_reg(
    input port_error_capture_pkg::reg_addr_t a);
    is_irq_reg = (a == `IRQ_STATUS_ADDR) || (a == `IRQ_CLEAR_ADDR) ||
      (a == `IRQ_ENABLE_ADDR);
  endfunction : is_irq_reg

  // ******************************************************************
  // Bus front end
  // ******************************************************************
  axil_reg_slave u_bus (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .awaddr_in(awaddr_in),
    .awvalid_in(awvalid_in),
    .awready_out(awready_out),
    .wdata_in(wdata_in),
    .wstrb_in(wstrb_in),
    .wvalid_in(wvalid_in),
    .wready_out(wready_out),
    .bresp_out(bresp_out),
    .bvalid_out(bvalid_out),
    .bready_in(bready_in),
    .araddr_in(araddr_in),
    .arvalid_in(arvalid_in),
    .arready_out(arready_out),
    .rdata_out(rdata_out),
    .rresp_out(rresp_out),
    .rvalid_out(rvalid_out),
    .rready_in(rready_in),
    .wr_out(wr),
    .wr_err_in(wr_err),
    .rd_fire_out(rd_fire),
    .rd_data_in(rd_data),
    .rd_err_in(rd_err)
  );

  // ******************************************************************
  // Per-port capture sets
  // ******************************************************************
  assign wr_sel = port_sel(wr.addr);
  assign wr_port = port_idx(wr.addr);

  for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port
    // Writing 0 to the valid bit unlocks the port; a 1 is ignored.
    assign clear_valid[p] = wr.valid && wr_sel == `ATTR_SEL &&
      wr_port == 2'(p) && wr.strb[0] && !wr.data[0];

    capture_port u_capture (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .req_in(capture_req_in[p]),
      .clear_in(clear_valid[p]),
      .attr_out(attr[p]),
      .words_out(words[p]),
      .event_out(capture_event[p])
    );
  end

  // Header words are read-only: writes to them are accepted and dropped.
  assign wr_err = (port_sel(wr.addr) == `NO_SEL) && !is_irq_reg(wr.addr);

  // ******************************************************************
  // Interrupt status, clear and enable
  // ******************************************************************
  assign irq_clear = (wr.valid && wr.addr == `IRQ_CLEAR_ADDR && wr.strb[0])
    ? wr.data[`NUM_PORTS-1:0] : '0;
  // A capture in the cycle of its clear keeps the status bit set.
  assign irq_status_nxt = capture_event | (irq_status_r & ~irq_clear);

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  assign enable_wr = wr.valid && wr.addr == `IRQ_ENABLE_ADDR && wr.strb[0];

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_enable_r <= '0;
    end else if (enable_wr) begin
      irq_enable_r <= wr.data[`NUM_PORTS-1:0];
    end
  end

  assign irq_out = |(irq_status_r & irq_enable_r);

  // ******************************************************************
  // Read mux
  // ******************************************************************
  always_comb begin
    logic [2:0] s;
    logic [1:0] p;
    s = port_sel(araddr_in);
    p = port_idx(araddr_in);
    rd_data = '0;
    rd_err = 1'b0;
    if (s == `ATTR_SEL) begin
      rd_data = attr[p];
    end else if (s != `NO_SEL) begin
      rd_data = words[p][s - 3'h1];
    end else if (araddr_in == `IRQ_STATUS_ADDR) begin
      rd_data[`NUM_PORTS-1:0] = irq_status_r;
    end else if (araddr_in == `IRQ_ENABLE_ADDR) begin
      rd_data[`NUM_PORTS-1:0] = irq_enable_r;
    end else if (araddr_in != `IRQ_CLEAR_ADDR) begin
      rd_err = 1'b1;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_chk
    a_capture_load: assert property (
      capture_req_in[p].valid && !attr[p].valid |=>
        attr[p].valid && attr[p].kind == $past(capture_req_in[p].kind) &&
        attr[p].err_code == $past(capture_req_in[p].err_code) &&
        words[p][0] == $past(capture_req_in[p].words[0]))
      else $error("unlocked capture did not load");

    a_locked_hold: assert property (
      attr[p].valid && !clear_valid[p] |=>
        attr[p].valid && $stable(words[p]) && $stable(attr[p].kind))
      else $error("locked capture was changed");

    a_clear_unlock: assert property (
      attr[p].valid && clear_valid[p] |=> !attr[p].valid ##1
        (!attr[p].valid || $past(capture_req_in[p].valid)))
      else $error("valid bit not cleared by write of zero");

    a_ctrl_sym_words: assert property (
      attr[p].valid && attr[p].kind == `KIND_CTRL_SYM |->
        words[p][1] == `CAPTURE_RESET && words[p][2] == `CAPTURE_RESET &&
        words[p][3] == `CAPTURE_RESET)
      else $error("control symbol capture left data beyond word 0");

    a_reserved_zero: assert property (
      !attr[p].rsvd_hi && attr[p].rsvd_lo == 3'h0)
      else $error("reserved attribute bits not zero");

    a_packet_words: assert property (
      capture_req_in[p].valid && !attr[p].valid &&
        capture_req_in[p].kind != `KIND_CTRL_SYM |=>
        words[p][3:1] == $past(capture_req_in[p].words[3:1]))
      else $error("packet header words not captured");

    a_status_sticky: assert property (
      capture_event[p] |=> irq_status_r[p] [*2] or
        (irq_status_r[p] ##1 $past(irq_clear[p])))
      else $error("capture event did not set status");

    a_status_set: assert property (
      capture_event[p] |=> irq_status_r[p])
      else $error("capture event did not set status at once");

    a_status_clear: assert property (
      irq_status_r[p] && irq_clear[p] && !capture_event[p] |=>
        !irq_status_r[p])
      else $error("status bit not cleared by write of one");

    a_attr_readback: assert property (
      rd_fire && port_sel(araddr_in) == `ATTR_SEL &&
        port_idx(araddr_in) == 2'(p) |=> rdata_out == $past(32'(attr[p])))
      else $error("attribute read returned the wrong word");

    a_hdr_readback: assert property (
      rd_fire && port_sel(araddr_in) != `ATTR_SEL &&
        port_sel(araddr_in) != `NO_SEL && port_idx(araddr_in) == 2'(p) |=>
        rdata_out == $past(words[p][port_sel(araddr_in) - 3'h1]))
      else $error("header word read returned the wrong word");

    a_sbit_words: assert property (
      capture_req_in[p].valid && !attr[p].valid &&
        capture_req_in[p].kind == `KIND_SBIT |=>
        attr[p].kind == `KIND_SBIT &&
        words[p] == $past(capture_req_in[p].words))
      else $error("S-bit capture not stored like a packet");
  end

  // ******************************************************************
  // Bus and interrupt checks
  // ******************************************************************

  a_words_ro: assert property (
    wr.valid && port_sel(wr.addr) != `ATTR_SEL &&
      port_sel(wr.addr) != `NO_SEL && !(|capture_event) |=>
      words[0] == $past(words[0]) && words[1] == $past(words[1]) &&
      words[2] == $past(words[2]) && words[3] == $past(words[3]))
    else $error("write changed a header word");

  a_irq_level: assert property (
    |(capture_event & irq_enable_r) && !enable_wr |=> irq_out)
    else $error("enabled capture did not raise the interrupt");

  a_enable_write: assert property (
    enable_wr |=> irq_enable_r == $past(wr.data[`NUM_PORTS-1:0]))
    else $error("interrupt enable write did not land");

  a_write_resp: assert property (
    wr.valid |=> bvalid_out && bresp_out == $past(wr_err ? `RESP_SLVERR :
      `RESP_OKAY))
    else $error("write response missing one cycle after write");

  a_read_hold: assert property (
    rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
    else $error("read data dropped before accepted");

  a_unmapped_read: assert property (
    rd_fire && port_sel(araddr_in) == `NO_SEL && !is_irq_reg(araddr_in) |=>
      rresp_out == `RESP_SLVERR && rdata_out == '0)
    else $error("unmapped read was not refused");

  a_read_answer: assert property (
    rd_fire |=> rvalid_out)
    else $error("read answer missing one cycle after address");

  // ******************************************************************
  // Coverage
  // ******************************************************************
  c_packet_capture: cover property (
    capture_req_in[0].valid && !attr[0].valid &&
      capture_req_in[0].kind == `KIND_PACKET);
  c_symbol_capture: cover property (
    capture_req_in[1].valid && !attr[1].valid &&
      capture_req_in[1].kind == `KIND_CTRL_SYM);
  c_clear_then_reload: cover property (
    clear_valid[1] ##[1:200] capture_event[1]);
  c_irq_raised: cover property (!irq_out ##1 irq_out);
  c_locked_drop: cover property (capture_req_in[1].valid && attr[1].valid);
endmodule : port_error_capture

// *** bench/port_error_capture_bench.sv ***
// Purpose: Self-checking bench for the four-port error capture bank.
// Assumes: AXI4-Lite master tasks; capture requests driven per port.
// Notes:   Expected values are built from the register layout only.
`timescale 1ns/1ps
`include "port_error_capture_regs.svh"
module port_error_capture_bench;
  logic sys_clk_in;
  logic resetn_in;
  port_error_capture_pkg::capture_req_t req [`NUM_PORTS];
  port_error_capture_pkg::capture_req_t cur [`NUM_PORTS];
  port_error_capture_pkg::reg_addr_t awaddr;
  port_error_capture_pkg::reg_addr_t araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [3:0] strb_sel;
  logic [1:0] bresp;
  logic [1:0] rresp;
  int num_errors;
  int samples_checked;

  port_error_capture i_dut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .capture_req_in(req),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
    .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
    .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
    .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
    .rvalid_out(rvalid), .rready_in(rready), .irq_out(irq)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task end_of_test;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task hang(input string name);
    num_errors++;
    $display("[ERR] %s expected response seen timeout", name);
    end_of_test();
  endtask : hang

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] exp_resp);
    logic aw_done;
    logic w_done;
    int n;
    @(posedge sys_clk_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= strb_sel;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    for (n = 0; n < 64; n++) begin
      @(posedge sys_clk_in);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        chk("bresp", 32'(exp_resp), 32'(bresp));
        bready <= 1'b0;
        break;
      end
    end
    if (n == 64) hang("bvalid");
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] exp_d,
                     input logic [1:0] exp_resp);
    logic ar_done;
    int n;
    @(posedge sys_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_done = 1'b0;
    for (n = 0; n < 64; n++) begin
      @(posedge sys_clk_in);
      if (!ar_done && arready) begin
        ar_done = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        chk("rdata", exp_d, rdata);
        chk("rresp", 32'(exp_resp), 32'(rresp));
        rready <= 1'b0;
        break;
      end
    end
    if (n == 64) hang("rvalid");
  endtask : axr

  function automatic logic [7:0] ra(int p, int s);
    return 8'(p * 32 + s * 4);
  endfunction : ra

  function automatic port_error_capture_pkg::capture_req_t mkreq(int p,
      logic [1:0] k, int variant);
    port_error_capture_pkg::capture_req_t c;
    c.valid = 1'b1;
    c.kind = k;
    c.err_code = 5'(p * 7 + variant);
    c.extra = 20'(32'h000A_BCDE + p + variant);
    for (int w = 0; w < 4; w++) begin
      c.words[w] = {8'(p), 8'(w), 8'(variant), 8'hA5};
    end
    return c;
  endfunction : mkreq

  task automatic chk_port(input int p,
      input port_error_capture_pkg::capture_req_t c, input logic v);
    port_error_capture_pkg::attr_t e;
    logic [31:0] ew;
    e = '0;
    e.kind = c.kind;
    e.err_code = c.err_code;
    e.extra = c.extra;
    e.valid = v;
    axr(ra(p, 0), e, `RESP_OKAY);
    for (int w = 0; w < 4; w++) begin
      ew = (c.kind == `KIND_CTRL_SYM && w > 0) ? 32'h0000_0000 : c.words[w];
      axr(ra(p, w + 1), ew, `RESP_OKAY);
    end
  endtask : chk_port

  task automatic pulse(input int p,
      input port_error_capture_pkg::capture_req_t c);
    @(posedge sys_clk_in);
    req[p] <= c;
    @(posedge sys_clk_in);
    req[p].valid <= 1'b0;
  endtask : pulse

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset_values;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      for (int s = 0; s < 5; s++) begin
        axr(ra(p, s), `CAPTURE_RESET, `RESP_OKAY);
      end
    end
    axr(`IRQ_STATUS_ADDR, 32'h0000_0000, `RESP_OKAY);
    chk("irq_out", 32'h0000_0000, 32'(irq));
  endtask : t_reset_values

  task t_capture_all;
    axw(`IRQ_ENABLE_ADDR, 32'h0000_0005, `RESP_OKAY);
    @(posedge sys_clk_in);
    for (int p = 0; p < `NUM_PORTS; p++) begin
      cur[p] = mkreq(p, 2'(p), 0);
      req[p] <= cur[p];
    end
    @(posedge sys_clk_in);
    for (int p = 0; p < `NUM_PORTS; p++) req[p].valid <= 1'b0;
    for (int p = 0; p < `NUM_PORTS; p++) chk_port(p, cur[p], 1'b1);
    axr(`IRQ_STATUS_ADDR, 32'h0000_000F, `RESP_OKAY);
    chk("irq_out", 32'h0000_0001, 32'(irq));
    axw(`IRQ_CLEAR_ADDR, 32'h0000_0005, `RESP_OKAY);
    axr(`IRQ_STATUS_ADDR, 32'h0000_000A, `RESP_OKAY);
    chk("irq_out", 32'h0000_0000, 32'(irq));
    axw(`IRQ_ENABLE_ADDR, 32'h0000_000F, `RESP_OKAY);
    chk("irq_out", 32'h0000_0001, 32'(irq));
    axw(`IRQ_CLEAR_ADDR, 32'h0000_000A, `RESP_OKAY);
    chk("irq_out", 32'h0000_0000, 32'(irq));
  endtask : t_capture_all

  task t_lock_unlock;
    port_error_capture_pkg::capture_req_t nxt;
    nxt = mkreq(1, `KIND_PACKET, 9);
    pulse(1, nxt);
    chk_port(1, cur[1], 1'b1);
    strb_sel = 4'hE;
    axw(ra(1, 0), 32'h0000_0000, `RESP_OKAY);
    strb_sel = 4'hF;
    chk_port(1, cur[1], 1'b1);
    axw(ra(1, 0), 32'h0000_0000, `RESP_OKAY);
    chk_port(1, cur[1], 1'b0);
    chk_port(0, cur[0], 1'b1);
    pulse(1, nxt);
    chk_port(1, nxt, 1'b1);
    chk("irq_out", 32'h0000_0001, 32'(irq));
    axw(ra(0, 1), 32'hFFFF_FFFF, `RESP_OKAY);
    axr(ra(0, 1), cur[0].words[0], `RESP_OKAY);
    axw(8'h14, 32'h0000_0000, `RESP_SLVERR);
    axr(8'h8C, 32'h0000_0000, `RESP_SLVERR);
  endtask : t_lock_unlock

  initial begin
    num_errors = 0;
    samples_checked = 0;
    resetn_in = 1'b0;
    for (int p = 0; p < `NUM_PORTS; p++) req[p] = '0;
    awaddr = '0;
    araddr = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = '0;
    wstrb = '0;
    strb_sel = 4'hF;
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    t_reset_values();
    t_capture_all();
    t_lock_unlock();
    end_of_test();
  end
endmodule : port_error_capture_bench
